// file: ptc_current.sv
// turns a seven-bit code into a current figure in microamps
// assumes the step size is fixed per instance
`include "ptc_map.svh"
module ptc_current
   import ptc_pkg::*;
#(
   parameter logic [9:0] STEP_UA = `PTC_GAIN_UA_STEP
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [6:0]  code,
   input  wire logic        enable,
   output logic [11:0]      ua
);
   logic [11:0] ua_reg, ua_next;

   // linear scale; product of 7 and 10 bits fits in 17, trimmed to 12
   always_comb begin
      logic [16:0] prod;
      prod    = 17'(code) * 17'(STEP_UA);
      ua_next = enable ? prod[11:0] : 12'h000;
   end

   always_ff @(posedge clk) begin
      if (rst)
         ua_reg <= 12'h000;
      else
         ua_reg <= ua_next;
   end

   assign ua = ua_reg;
endmodule : ptc_current

// file: ptc_forwarder.sv
// serialises one forwarding word into the vco subsystem
// assumes start is held off while busy is high
`include "ptc_map.svh"
module ptc_forwarder
   import ptc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [11:0] word,
   output logic             busy,
   output logic             sclk,
   output logic             sdata,
   output logic             sload
);
   ptc_fw_state_t state_reg, state_next;
   logic [3:0]  div_reg, div_next;
   logic [4:0]  cnt_reg, cnt_next;
   logic [11:0] sh_reg, sh_next;
   logic        ck_reg, ck_next;
   logic        tick;

   // divider gives one enable pulse per half bit
   assign tick = (div_reg == `PTC_FWD_DIV - 4'd1);

   // shift msb first, one bit per slow clock period
   always_comb begin
      state_next = state_reg;
      div_next   = (state_reg == PTC_FW_IDLE || tick) ? 4'd0
                                                      : div_reg + 4'd1;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      ck_next    = ck_reg;
      unique case (state_reg)
         PTC_FW_IDLE: begin
            if (start) begin
               sh_next    = word;
               cnt_next   = 5'd0;
               ck_next    = 1'b0;
               state_next = PTC_FW_SHIFT;
            end
         end
         PTC_FW_SHIFT: begin
            if (tick) begin
               ck_next = ~ck_reg;
               if (ck_reg) begin
                  sh_next  = {sh_reg[10:0], 1'b0};
                  cnt_next = cnt_reg + 5'd1;
                  if (cnt_reg == `PTC_FWD_BITS - 5'd1)
                     state_next = PTC_FW_DONE;
               end
            end
         end
         PTC_FW_DONE: begin
            if (tick)
               state_next = PTC_FW_IDLE;
         end
         default: state_next = PTC_FW_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= PTC_FW_IDLE;
         div_reg   <= 4'd0;
         cnt_reg   <= 5'd0;
         sh_reg    <= 12'h000;
         ck_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         div_reg   <= div_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         ck_reg    <= ck_next;
      end
   end

   assign busy  = (state_reg != PTC_FW_IDLE);
   assign sclk  = ck_reg;
   assign sdata = sh_reg[11];
   assign sload = (state_reg == PTC_FW_DONE);
endmodule : ptc_forwarder

// file: ptc_map.svh
// register map, field positions, reset values and timing for the tuning block
// assumes word-aligned ahb-lite access; included by bare name
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH
// printed register indices; byte address is four times the index
`define PTC_IDX_REFDIV     6'h02
`define PTC_IDX_INTDIV     6'h03
`define PTC_IDX_FRACWORD   6'h04
`define PTC_IDX_FORWARD    6'h05
`define PTC_IDX_MODCFG     6'h06
`define PTC_IDX_PUMP       6'h09
`define PTC_IDX_PHASECTL   6'h0b
`define PTC_IDX_STATUS     6'h10
`define PTC_IDX_VCOSHADOW2 6'h11
`define PTC_IDX_VCOSHADOW3 6'h12
// phase comparator control fields
`define PTC_SLIP_HI        8
`define PTC_SLIP_LO        7
// pump register fields
`define PTC_DN_GAIN_HI     6
`define PTC_DN_GAIN_LO     0
`define PTC_UP_GAIN_HI     13
`define PTC_UP_GAIN_LO     7
`define PTC_OFS_HI         20
`define PTC_OFS_LO         14
`define PTC_OFS_UP_BIT     21
`define PTC_OFS_DN_BIT     22
// current scaling: 20 ua per gain step, 5 ua per offset step
`define PTC_GAIN_UA_STEP   10'd20
`define PTC_OFS_UA_STEP    10'd5
// modulator configuration bits
`define PTC_FRAC_EN_BIT    11
`define PTC_DSM_BYP_BIT    7
// divider limits
`define PTC_INT_MIN        19'd16
`define PTC_FRAC_MIN       19'd20
// forwarding word: [2:0] vco register, [11:3] vco data
`define PTC_FWD_ADDR_HI    2
`define PTC_FWD_ADDR_LO    0
`define PTC_FWD_DATA_HI    11
`define PTC_FWD_DATA_LO    3
`define PTC_VCO_OUTDIV     3'h2
`define PTC_VCO_DOUBLER    3'h3
`define PTC_OUTDIV_HI      5
`define PTC_OUTDIV_LO      0
`define PTC_DBL_BIT        0
// reset values
`define PTC_RST_REFDIV     14'h0001
`define PTC_RST_INTDIV     19'h00014
`define PTC_RST_FRAC       24'h000000
`define PTC_RST_MODCFG     12'h080
`define PTC_RST_PUMP       23'h000000
`define PTC_RST_PHASECTL   11'h000
`define PTC_RST_OUTDIV     6'h01
// forwarding serial clock divider (core cycles per half bit)
`define PTC_FWD_DIV        4'd4
`define PTC_FWD_BITS       5'd12
`endif

// file: ptc_pkg.sv
// types shared by the tuning block and its helpers
// assumes ptc_map.svh supplies numeric constants
package ptc_pkg;
   typedef enum logic [1:0] {PTC_MODE_INT, PTC_MODE_FRAC,
                             PTC_MODE_MIXED} ptc_mode_t;
   typedef enum logic [1:0] {PTC_FW_IDLE, PTC_FW_SHIFT,
                             PTC_FW_DONE} ptc_fw_state_t;
endpackage : ptc_pkg

// file: ptc_tuning_ctrl.sv
// tuning and charge-pump control registers of the synthesizer
// assumes a single ahb-lite master on CORE_CLK and synchronous RST
// assumes whole-word accesses; HSIZE is not decoded
// the analog loop, lock detect and band calibration lie outside
//
// Design decision made here: register access over AHB-Lite.
`include "ptc_map.svh"
module ptc_tuning_ctrl
   import ptc_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic [1:0]       SLIP_PREVENTION_THRESHOLD,
   output logic [11:0]      DOWN_PUMP_UA,
   output logic [11:0]      UP_PUMP_UA,
   output logic [11:0]      OFFSET_UP_UA,
   output logic [11:0]      OFFSET_DN_UA,
   output logic             FRAC_MOD_EN,
   output logic             DSM_BYPASS,
   output logic [18:0]      FEEDBACK_DIV,
   output logic [23:0]      FRACTION_WORD,
   output logic [13:0]      REFERENCE_DIV,
   output logic             VCO_SCLK,
   output logic             VCO_SDATA,
   output logic             VCO_SLOAD
);
   import ptc_pkg::*;

   // byte addresses are the register index times four:
   //   0x08 reference divider      0x0c integer ratio
   //   0x10 fraction word          0x14 forwarding word
   //   0x18 modulator config       0x24 pump gains and offset
   //   0x2c phase comparator ctl   0x40 status, read only
   //   0x44 output divider shadow  0x48 doubler shadow
   // status: [4] divider below floor, [3:2] mode, [1] word queued,
   // [0] forwarder busy; every other index reads zero, drops writes
   // pump word: [6:0] down gain, [13:7] up gain, [20:14] offset size,
   // [21] up offset enable, [22] down offset enable
   // forwarding word: [2:0] vco register, [11:3] its data; registers
   // 2 and 3 are shadowed here so software can read them back
   // software-visible registers and the forwarding queue
   logic [13:0] refdiv_reg, refdiv_next;
   logic [18:0] intdiv_reg, intdiv_next;
   logic [23:0] frac_reg_q, frac_next;
   logic [11:0] modcfg_reg, modcfg_next;
   logic [22:0] pump_reg, pump_next;
   logic [10:0] phase_reg, phase_next;
   logic [5:0]  outdiv_reg, outdiv_next;
   logic        dbl_reg, dbl_next;
   logic        range_err_reg, range_err_next;
   logic        pend_reg, pend_next;
   logic [11:0] fwd_reg, fwd_next;
   logic        wr_ph_reg, wr_ph_next;
   logic [5:0]  idx_reg, idx_next;
   logic [31:0] rdata_reg, rdata_next;
   // handshake with the forwarder and the bus decode
   logic        fw_busy;
   logic        fw_start;
   logic        fw_stall;
   logic        take;
   logic [5:0]  rd_idx;
   ptc_mode_t   mode;

   // address phase accepted only when a write is not waiting to forward;
   // idle and busy transfers start no data phase
   assign take     = HSEL && HREADY && HTRANS[1];
   // one word may wait in the queue while the forwarder shifts the one
   // before; a further forwarding write holds the bus in its data phase
   // rather than overwrite the queued word
   assign fw_stall = wr_ph_reg && idx_reg == `PTC_IDX_FORWARD && pend_reg;
   assign rd_idx   = HADDR[7:2];
   // the forwarder takes the queued word as soon as it is idle
   assign fw_start = pend_reg && !fw_busy;

   // mode decode from the two modulator bits; a pair set or cleared together counts as
   // mixed and keeps the fraction live, since the modulator may run;
   // mixed is legal to write but only reported, never corrected
   always_comb begin
      if (!modcfg_reg[`PTC_FRAC_EN_BIT] && modcfg_reg[`PTC_DSM_BYP_BIT])
         mode = PTC_MODE_INT;
      else if (modcfg_reg[`PTC_FRAC_EN_BIT]
               && !modcfg_reg[`PTC_DSM_BYP_BIT])
         mode = PTC_MODE_FRAC;
      else
         mode = PTC_MODE_MIXED;
   end

   // data-phase write, read mux and forwarding queue
   always_comb begin
      refdiv_next    = refdiv_reg;
      intdiv_next    = intdiv_reg;
      frac_next      = frac_reg_q;
      modcfg_next    = modcfg_reg;
      pump_next      = pump_reg;
      phase_next     = phase_reg;
      outdiv_next    = outdiv_reg;
      dbl_next       = dbl_reg;
      pend_next      = pend_reg;
      fwd_next       = fwd_reg;
      wr_ph_next     = fw_stall ? wr_ph_reg : 1'b0;
      idx_next       = idx_reg;
      rdata_next     = rdata_reg;
      range_err_next = range_err_reg;
      // the queue clears as the forwarder starts; a new word cannot land
      // in that same cycle because its write is still stalled
      // forwarder takes the queued word once
      if (fw_start)
         pend_next = 1'b0;
      // data phase of an accepted write: the word lands at its end
      if (wr_ph_reg && !fw_stall) begin
         unique case (idx_reg)
            `PTC_IDX_REFDIV:   refdiv_next = HWDATA[13:0];
            `PTC_IDX_INTDIV:   intdiv_next = HWDATA[18:0];
            `PTC_IDX_FRACWORD: frac_next   = HWDATA[23:0];
            `PTC_IDX_MODCFG:   modcfg_next = HWDATA[11:0];
            `PTC_IDX_PUMP:     pump_next   = HWDATA[22:0];
            `PTC_IDX_PHASECTL: phase_next  = HWDATA[10:0];
            // vco writes only through the forwarder
            `PTC_IDX_FORWARD: begin
               fwd_next  = HWDATA[11:0];
               pend_next = 1'b1;
               if (HWDATA[`PTC_FWD_ADDR_HI:`PTC_FWD_ADDR_LO]
                   == `PTC_VCO_OUTDIV)
                  outdiv_next = HWDATA[`PTC_FWD_DATA_LO+`PTC_OUTDIV_HI:
                                       `PTC_FWD_DATA_LO];
               if (HWDATA[`PTC_FWD_ADDR_HI:`PTC_FWD_ADDR_LO]
                   == `PTC_VCO_DOUBLER)
                  dbl_next = HWDATA[`PTC_FWD_DATA_LO+`PTC_DBL_BIT];
            end
            // unmapped and read-only indices drop the write
            default: ;
         endcase
      end
      // a level flag: it follows the registers and needs no clear
      // flag a divider below the mode's legal floor
      range_err_next = (mode == PTC_MODE_INT && intdiv_reg < `PTC_INT_MIN)
                    || (mode == PTC_MODE_FRAC
                        && intdiv_reg < `PTC_FRAC_MIN);
      // read data other than status comes from the next-state values, so a read right
      // behind a write to the same register already sees the new word;
      // the registered copies alone would lag by one transfer
      if (take && !fw_stall) begin
         wr_ph_next = HWRITE;
         idx_next   = rd_idx;
         unique case (rd_idx)
            `PTC_IDX_REFDIV:     rdata_next = {18'h0, refdiv_next};
            `PTC_IDX_INTDIV:     rdata_next = {13'h0, intdiv_next};
            `PTC_IDX_FRACWORD:   rdata_next = {8'h0, frac_next};
            `PTC_IDX_FORWARD:    rdata_next = {20'h0, fwd_next};
            `PTC_IDX_MODCFG:     rdata_next = {20'h0, modcfg_next};
            `PTC_IDX_PUMP:       rdata_next = {9'h0, pump_next};
            `PTC_IDX_PHASECTL:   rdata_next = {21'h0, phase_next};
            // status and the two shadows are read only
            `PTC_IDX_STATUS:     rdata_next = {27'h0, range_err_reg,
                                               mode, pend_reg, fw_busy};
            `PTC_IDX_VCOSHADOW2: rdata_next = {26'h0, outdiv_next};
            `PTC_IDX_VCOSHADOW3: rdata_next = {31'h0, dbl_next};
            default:             rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // reset leaves integer mode with a divider already legal for the
   // fractional floor, so a later mode switch needs no rewrite first
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         refdiv_reg    <= `PTC_RST_REFDIV;
         intdiv_reg    <= `PTC_RST_INTDIV;
         frac_reg_q    <= `PTC_RST_FRAC;
         modcfg_reg    <= `PTC_RST_MODCFG;
         pump_reg      <= `PTC_RST_PUMP;
         phase_reg     <= `PTC_RST_PHASECTL;
         outdiv_reg    <= `PTC_RST_OUTDIV;
         dbl_reg       <= 1'b0;
         range_err_reg <= 1'b0;
         pend_reg      <= 1'b0;
         fwd_reg       <= 12'h000;
         wr_ph_reg     <= 1'b0;
         idx_reg       <= 6'h00;
         rdata_reg     <= 32'h0000_0000;
      end else begin
         refdiv_reg    <= refdiv_next;
         intdiv_reg    <= intdiv_next;
         frac_reg_q    <= frac_next;
         modcfg_reg    <= modcfg_next;
         pump_reg      <= pump_next;
         phase_reg     <= phase_next;
         outdiv_reg    <= outdiv_next;
         dbl_reg       <= dbl_next;
         range_err_reg <= range_err_next;
         pend_reg      <= pend_next;
         fwd_reg       <= fwd_next;
         wr_ph_reg     <= wr_ph_next;
         idx_reg       <= idx_next;
         rdata_reg     <= rdata_next;
      end
   end

   // a second forwarding write waits here rather than overwrite the queue
   assign HREADYOUT = !fw_stall;
   // the response is always okay: unmapped or odd accesses are absorbed
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_reg;

   // slip, modulator and divider outputs are register taps with no extra delay; the fraction word is gated by mode
   // threshold field straight to the comparator
   assign SLIP_PREVENTION_THRESHOLD = phase_reg[`PTC_SLIP_HI:`PTC_SLIP_LO];
   // modulator controls follow the register bits
   assign FRAC_MOD_EN   = modcfg_reg[`PTC_FRAC_EN_BIT];
   assign DSM_BYPASS    = modcfg_reg[`PTC_DSM_BYP_BIT];
   // the loop reads the divider words directly; with no double buffer
   // a host changing both words sees at least one cycle of a mixed ratio
   // divider words feed the loop, vco = ref / r * (n + f)
   assign FEEDBACK_DIV  = intdiv_reg;
   // fraction forced to zero in integer mode only, the register kept
   // so the stored fraction reaches the modulator again after a switch back
   assign FRACTION_WORD = (mode == PTC_MODE_INT) ? 24'h000000 : frac_reg_q;
   assign REFERENCE_DIV = refdiv_reg;

   // currents are registered one cycle behind the pump register, so all
   // four change together; a cleared offset enable forces zero current
   // gain codes to current, 20 ua per step
   ptc_current #(.STEP_UA(`PTC_GAIN_UA_STEP)) u_dn_gain (
      .clk    (CORE_CLK),
      .rst    (RST),
      .code   (pump_reg[`PTC_DN_GAIN_HI:`PTC_DN_GAIN_LO]),
      .enable (1'b1),
      .ua     (DOWN_PUMP_UA)
   );
   ptc_current #(.STEP_UA(`PTC_GAIN_UA_STEP)) u_up_gain (
      .clk    (CORE_CLK),
      .rst    (RST),
      .code   (pump_reg[`PTC_UP_GAIN_HI:`PTC_UP_GAIN_LO]),
      .enable (1'b1),
      .ua     (UP_PUMP_UA)
   );
   // offset at 5 ua per code
   ptc_current #(.STEP_UA(`PTC_OFS_UA_STEP)) u_ofs_up (
      .clk    (CORE_CLK),
      .rst    (RST),
      .code   (pump_reg[`PTC_OFS_HI:`PTC_OFS_LO]),
      .enable (pump_reg[`PTC_OFS_UP_BIT]),
      .ua     (OFFSET_UP_UA)
   );
   ptc_current #(.STEP_UA(`PTC_OFS_UA_STEP)) u_ofs_dn (
      .clk    (CORE_CLK),
      .rst    (RST),
      .code   (pump_reg[`PTC_OFS_HI:`PTC_OFS_LO]),
      .enable (pump_reg[`PTC_OFS_DN_BIT]),
      .ua     (OFFSET_DN_UA)
   );

   // the serial clock idles low between frames and the load strobe
   // follows the last bit; the word is latched at start, so the queue
   // may refill while a frame is still shifting
   // band changes only via divider or doubler over this port
   ptc_forwarder u_fwd (
      .clk   (CORE_CLK),
      .rst   (RST),
      .start (fw_start),
      .word  (fwd_reg),
      .busy  (fw_busy),
      .sclk  (VCO_SCLK),
      .sdata (VCO_SDATA),
      .sload (VCO_SLOAD)
   );
endmodule : ptc_tuning_ctrl

// file: ptc_tuning_ctrl_checker.sv
// assertions on the tuning block's register effects and forwarding port
// assumes one master whose hready is the block's own HREADYOUT
module ptc_tuning_ctrl_checker (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic        HREADYOUT,
   input wire logic [1:0]  SLIP_PREVENTION_THRESHOLD,
   input wire logic [11:0] DOWN_PUMP_UA,
   input wire logic [11:0] UP_PUMP_UA,
   input wire logic [11:0] OFFSET_UP_UA,
   input wire logic [11:0] OFFSET_DN_UA,
   input wire logic        FRAC_MOD_EN,
   input wire logic        DSM_BYPASS,
   input wire logic [18:0] FEEDBACK_DIV,
   input wire logic [23:0] FRACTION_WORD,
   input wire logic        VCO_SLOAD
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wp_reg, wp_next;
   logic [31:0] wa_reg, wa_next, wd_reg, wd_next;
   // last write: its address phase, then the word of its data phase
   always_comb begin
      wp_next = HREADY ? (HSEL & HTRANS[1] & HWRITE) : wp_reg;
      wa_next = HREADY ? HADDR : wa_reg;
      wd_next = (wp_reg && HREADY) ? HWDATA : wd_reg;
   end
   always_ff @(posedge CORE_CLK) begin
      wp_reg <= RST ? 1'b0 : wp_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_wr(logic [31:0] a);
      wp_reg && HREADY && wa_reg == a;
   endsequence
   // quiet cycles give registered outputs time to follow the write
   sequence s_settled(logic [31:0] a);
      s_wr(a) ##1 (!wp_reg) [*4];
   endsequence
   a_slip_field: assert property (s_settled(32'h2c) |->
      SLIP_PREVENTION_THRESHOLD == wd_reg[8:7])
      else $error("slip threshold field mismatch");
   a_pump_gain: assert property (s_settled(32'h24) |->
      DOWN_PUMP_UA == 12'(wd_reg[6:0]) * 12'd20 &&
      UP_PUMP_UA == 12'(wd_reg[13:7]) * 12'd20)
      else $error("pump current does not follow gain code");
   a_pump_offset: assert property (s_settled(32'h24) |->
      OFFSET_UP_UA == (wd_reg[21] ? 12'(wd_reg[20:14]) * 12'd5 : 12'h0) &&
      OFFSET_DN_UA == (wd_reg[22] ? 12'(wd_reg[20:14]) * 12'd5 : 12'h0))
      else $error("offset current mismatch");
   a_mode_bits: assert property (s_settled(32'h18) |->
      FRAC_MOD_EN == wd_reg[11] && DSM_BYPASS == wd_reg[7])
      else $error("modulator mode bits mismatch");
   a_int_divider: assert property (s_settled(32'h0c) |->
      FEEDBACK_DIV == wd_reg[18:0])
      else $error("feedback divider mismatch");
   a_int_no_frac: assert property (
      (!FRAC_MOD_EN && DSM_BYPASS) [*3] |-> FRACTION_WORD == 24'h0)
      else $error("fraction active in integer mode");
   a_fwd_frame: assert property (
      s_wr(32'h14) |-> ##[90:400] $rose(VCO_SLOAD))
      else $error("forward write never loaded");
   a_load_width: assert property (
      $rose(VCO_SLOAD) |-> VCO_SLOAD [*4] ##1 !VCO_SLOAD)
      else $error("load pulse width wrong");
   a_stall_bound: assert property (
      $fell(HREADYOUT) |-> ##[1:120] HREADYOUT)
      else $error("forward stall too long");
endmodule : ptc_tuning_ctrl_checker
bind ptc_tuning_ctrl ptc_tuning_ctrl_checker i_ptc_tuning_ctrl_checker (
   .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HREADYOUT(HREADYOUT), .DOWN_PUMP_UA(DOWN_PUMP_UA),
   .SLIP_PREVENTION_THRESHOLD(SLIP_PREVENTION_THRESHOLD),
   .UP_PUMP_UA(UP_PUMP_UA), .OFFSET_UP_UA(OFFSET_UP_UA),
   .OFFSET_DN_UA(OFFSET_DN_UA), .FRAC_MOD_EN(FRAC_MOD_EN),
   .DSM_BYPASS(DSM_BYPASS), .FEEDBACK_DIV(FEEDBACK_DIV),
   .FRACTION_WORD(FRACTION_WORD), .VCO_SLOAD(VCO_SLOAD)
);

// file: ptc_tuning_ctrl_tb.sv
// self-checking bench for the tuning and pump control block
// assumes the vco serial model stands on the forwarding port
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
`include "ptc_map.svh"
module ptc_tuning_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, hsel, hwrite, hready, hresp, fen, byp;
   logic        sclk, sdata, sload, m_dbl, m;
   logic [1:0]  htrans, slip;
   logic [5:0]  m_div;
   logic [7:0]  m_cnt;
   logic [11:0] dn_ua, up_ua, ou_ua, od_ua;
   logic [13:0] rdiv;
   logic [18:0] fdiv;
   logic [23:0] fword;
   logic [31:0] haddr, hwdata, rdata, q, w, seed;
   int          error_cnt = 0, num_checks = 0, cyc = 0;
   // the slave's own ready is the bus's hready
   ptc_tuning_ctrl i_ptc_tuning_ctrl (
      .CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(rdata), .HREADYOUT(hready), .HRESP(hresp),
      .SLIP_PREVENTION_THRESHOLD(slip), .DOWN_PUMP_UA(dn_ua),
      .UP_PUMP_UA(up_ua), .OFFSET_UP_UA(ou_ua), .OFFSET_DN_UA(od_ua),
      .FRAC_MOD_EN(fen), .DSM_BYPASS(byp), .FEEDBACK_DIV(fdiv),
      .FRACTION_WORD(fword), .REFERENCE_DIV(rdiv), .VCO_SCLK(sclk),
      .VCO_SDATA(sdata), .VCO_SLOAD(sload)
   );
   ptc_vco_model i_ptc_vco_model (
      .sclk(sclk), .sdata(sdata), .sload(sload),
      .out_div(m_div), .dbl_sel(m_dbl), .n_loads(m_cnt)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // bench sequence source and expectations
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic logic [11:0] ua(input logic [6:0] c, input int s);
      return 12'(c) * 12'(s);
   endfunction : ua
   function automatic logic [31:0] adr(input logic [5:0] idx);
      return {24'h0, idx, 2'b00};
   endfunction : adr
   // sample at the falling edge: ready is settled until the next rise
   task automatic hs();
      logic r;
      do begin
         @(negedge clk);
         r = hready;
         q = rdata;
         @(posedge clk);
      end while (r !== 1'b1);
   endtask : hs
   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      hs();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hs();
   endtask : bus
   // write, then let registered outputs settle before looking
   task automatic wri(input logic [31:0] a, d);
      bus(1'b1, a, d);
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : wri
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // a hang ends the run; the tests need about 800 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      seed = 32'hcf023585;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, adr(`PTC_IDX_INTDIV), 32'h0);
      `CHK(q, 32'h14)
      bus(1'b0, adr(`PTC_IDX_MODCFG), 32'h0);
      `CHK(q, 32'h80)
      wri(32'h3c, 32'hffffffff);
      bus(1'b0, 32'h3c, 32'h0);
      `CHK(q, 32'h0)
      $display("test reset_and_unmapped done");
      for (int i = 0; i < 4; i++) begin
         wri(adr(`PTC_IDX_PHASECTL), 32'(i) << 7);
         `CHK(slip, 2'(i))
      end
      $display("test slip_threshold done");
      // fractional mode with down offset on
      wri(adr(`PTC_IDX_MODCFG), 32'h800);
      for (int i = 0; i < 10; i++) begin
         w = (i == 0) ? 32'h7fffff : (i == 1) ? 32'h0 : rnd() & 32'h7fffff;
         w[22] = 1'b1;
         wri(adr(`PTC_IDX_PUMP), w);
         `CHK(dn_ua, ua(w[6:0], 20))
         `CHK(up_ua, ua(w[13:7], 20))
         `CHK(ou_ua, w[21] ? ua(w[20:14], 5) : 12'h0)
         `CHK(od_ua, w[22] ? ua(w[20:14], 5) : 12'h0)
         bus(1'b0, adr(`PTC_IDX_PUMP), 32'h0);
         `CHK(q, w)
      end
      $display("test pump_gain_offset done");
      for (int i = 0; i < 6; i++) begin
         w = rnd();
         m = i[0];
         // offset off before integer, on after fractional
         wri(adr(`PTC_IDX_PUMP), 32'h1932);
         wri(adr(`PTC_IDX_MODCFG), m ? 32'h800 : 32'h080);
         if (m) wri(adr(`PTC_IDX_PUMP), 32'h501932);
         // divider kept at or above twenty
         wri(adr(`PTC_IDX_INTDIV), {13'h0, w[18:0] | 19'h20});
         wri(adr(`PTC_IDX_FRACWORD), {8'h0, w[31:8]});
         wri(adr(`PTC_IDX_REFDIV), {18'h0, w[13:0] | 14'h1});
         `CHK({fen, byp}, {m, ~m})
         `CHK(fdiv, w[18:0] | 19'h20)
         `CHK(fword, m ? w[31:8] : 24'h0)
         `CHK(rdiv, w[13:0] | 14'h1)
         `CHK(od_ua, m ? ua(7'h40, 5) : 12'h0)
      end
      $display("test modes_and_dividers done");
      // third write finds the second still queued, so the bus stalls
      bus(1'b1, adr(`PTC_IDX_FORWARD), {20'h0, 9'd62, 3'h2});
      bus(1'b1, adr(`PTC_IDX_FORWARD), {20'h0, 9'd0, 3'h3});
      bus(1'b1, adr(`PTC_IDX_FORWARD), {20'h0, 9'd1, 3'h3});
      while (m_cnt !== 8'd3) @(posedge clk);
      repeat (20) @(posedge clk);
      `CHK(m_cnt, 8'd3)
      `CHK(m_div, 6'd62)
      `CHK(m_dbl, 1'b1)
      bus(1'b0, adr(`PTC_IDX_VCOSHADOW2), 32'h0);
      `CHK(q, 32'd62)
      bus(1'b0, adr(`PTC_IDX_VCOSHADOW3), 32'h0);
      `CHK(q, 32'h1)
      bus(1'b0, adr(`PTC_IDX_STATUS), 32'h0);
      `CHK(q, 32'h4)
      `CHK(hresp, 1'b0)
      $display("test forwarding done");
      give_verdict();
   end
endmodule : ptc_tuning_ctrl_tb

// file: ptc_vco_model.sv
// behavioural vco subsystem register port on the forwarding link
// assumes bits msb first, sampled at the rising serial clock
module ptc_vco_model (
   input  wire logic       sclk,
   input  wire logic       sdata,
   input  wire logic       sload,
   output logic [5:0]      out_div,
   output logic            dbl_sel,
   output logic [7:0]      n_loads
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] shift_q = 12'h000;
   // start values of out_div and dbl_sel are arbitrary; only their written values are compared
   initial begin
      out_div = 6'h01;
      dbl_sel = 1'b0;
      n_loads = 8'h00;
   end
   always @(posedge sclk) shift_q = {shift_q[10:0], sdata};
   always @(posedge sload) begin
      n_loads = n_loads + 8'h01;
      if (shift_q[2:0] == 3'h2) out_div = shift_q[8:3];
      if (shift_q[2:0] == 3'h3) dbl_sel = shift_q[3];
   end
endmodule : ptc_vco_model
